// ==== touch_setup_block.sv ====
`timescale 1ns/1ns
// What this block does
// - Bursts start at fixed spacing, 500us to 3000us in 250us steps, indices 1-11.
// - Spacing index 0 fixes a best-fit slot per key at power-up until reset.
// - Serial rate index 0-4 picks 9600 to 115200 baud, async mode only.
// - Error raised when any key reference drops below the 16-bit lower limit.
// - Alert pin active when any enabled condition holds, all ORed.
// - Alert byte bit 7 selects polarity, 1 active high, default 0.
// - Bit 6 alerts on key errors, bit 5 on key press, both default 1.
// - Bits 4, 3, 2 alert on sleep, storage error, mains sync error.
// - Bit 1 alerts on unknown command until get-last-command or reset.
// - Bit 0: 150ms host reset pulse after 2s silence, armed by first valid command.
// - Alert level held during sleep unless bit 4 set; alert byte defaults to 0x6C.
// - Block accepted only after two consecutive 0x01 commands.
// - Block is 247 bytes, last two are CRC of the rest.
// - CRC-16, seed zero, polynomial 0x1021, byte into upper half, MSB first.
// - CRC-8, seed zero, polynomial 0x8C reflected, LSB first.
// - Report-all-keys 0x07 returns six bytes, byte Y holds bit X, key 8Y+X.
// - Threshold byte: low nibble negative, high nibble positive, each plus 4.
// - Integrator byte: low nibble normal, high fast; normal 0 disables bursts.
// - Negative recal delay is 8 bits in 0.5s units, 0 never, default 20.
// - Option byte: positive recal low nibble, burst length 5:4, suppression 6, scope 7.
// - Global byte: dwell 5:4, mains sync 6, hysteresis 1:0.
// - Mains sync waits up to 100ms after a scan for a falling sync edge.
module touch_setup_block
	import touch_setup_pkg::*;
#(
	parameter int unsigned TICK_LEN = TICK_CYCLES,
	parameter int unsigned WDOG_LEN = WDOG_TICKS
) (
	input wire logic sys_clk,
	input wire logic reset,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [47:0] key_touch,
	input wire logic [15:0] ref_level,
	input wire logic [5:0] ref_key,
	input wire logic ref_valid,
	input wire logic cal_error,
	input wire logic sleep_active,
	input wire logic eeprom_error,
	input wire logic wake_sync_pin,
	output logic alert_pin,
	output logic burst_start,
	output logic [5:0] burst_key,
	output logic [4:0] neg_threshold,
	output logic [4:0] pos_threshold,
	output logic [3:0] normal_integrator_limit,
	output logic [3:0] fast_integrator_limit,
	output logic [7:0] negative_recal_delay,
	output logic [3:0] positive_recal_delay,
	output logic [6:0] burst_length,
	output logic adjacent_suppress_enable,
	output logic scope_pulse_enable,
	output logic [1:0] drop_out_hysteresis,
	output logic [1:0] dwell_select,
	output logic mains_sync_enable,
	output logic [13:0] serial_divisor,
	output logic key_error
);
	typedef enum logic [2:0] {LD_IDLE = 3'b001, LD_ARM = 3'b010, LD_SETUP = 3'b100} load_state_t;
	typedef enum logic [1:0] {SC_RUN = 2'b01, SC_WAIT_SYNC = 2'b10} scan_state_t;

	function automatic logic [7:0] default_byte(input int unsigned idx);
		if (idx < OFS_DRIFT) return DEF_THRESH;
		if (idx < OFS_INTEG) return DEF_DRIFT;
		if (idx < OFS_NEG_RECAL) return DEF_INTEG;
		if (idx < OFS_OPT) return DEF_NEG_RECAL;
		if (idx < OFS_GLOBAL) return DEF_OPT;
		if (idx == OFS_GLOBAL) return DEF_GLOBAL;
		if (idx == OFS_LIMIT_LO) return DEF_LIMIT[7:0];
		if (idx == OFS_LIMIT_HI) return DEF_LIMIT[15:8];
		if (idx == OFS_ALERT) return DEF_ALERT;
		return DEF_SPACE;
	endfunction

	function automatic logic [13:0] baud_div(input logic [3:0] idx);
		unique case (idx)
			4'h1: return 14'(CLK_HZ / 19200);
			4'h2: return 14'(CLK_HZ / 38400);
			4'h3: return 14'(CLK_HZ / 57600);
			4'h4: return 14'(CLK_HZ / 115200);
			default: return 14'(CLK_HZ / 9600);
		endcase
	endfunction

	// ********************************
	// APB slave
	// ********************************
	logic [7:0] live [DATA_LEN];
	logic [7:0] stage [DATA_LEN];
	load_state_t ld_state;
	scan_state_t sc_state;
	logic [7:0] blk_idx, rx_crc_lo, last_cmd, resp_crc;
	logic [15:0] crc_acc;
	logic [7:0] resp_buf [RESP_LEN];
	logic [2:0] resp_cnt, resp_rd;
	logic commit, load_ok, load_bad, comms_err, wd_armed, hreset_active, mains_sync_enable_err;
	logic [47:0] low_vec;
	logic access, cmd_strobe, data_strobe, resp_pop, known_cmd;
	logic [7:0] alert_cfg;
	logic [15:0] low_limit;
	logic alert_cond;

	assign access = psel && penable && pready;
	assign cmd_strobe = access && pwrite && paddr == ADDR_CMD;
	assign data_strobe = access && pwrite && paddr == ADDR_BLOCK;
	assign resp_pop = access && !pwrite && paddr == ADDR_RESP && resp_rd != resp_cnt;
	assign known_cmd = pwdata[7:0] == CMD_SETUP || pwdata[7:0] == CMD_ALL_KEYS || pwdata[7:0] == CMD_GET_LAST;
	assign alert_cfg = live[OFS_ALERT];
	assign low_limit = {live[OFS_LIMIT_HI], live[OFS_LIMIT_LO]};

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0000_0000;
		end else if (psel && !penable) begin
			pready <= 1'b1;
			pslverr <= paddr > ADDR_RESP_CRC || paddr[1:0] != 2'h0;
			unique case (paddr)
				ADDR_STATUS: prdata <= {23'h0, resp_cnt - resp_rd, mains_sync_enable_err, wd_armed, comms_err, load_bad,
					load_ok, ld_state == LD_SETUP};
				ADDR_RESP: prdata <= {24'h0, resp_rd != resp_cnt ? resp_buf[resp_rd] : 8'h00};
				ADDR_LAST: prdata <= {24'h0, last_cmd};
				ADDR_RESP_CRC: prdata <= {24'h0, resp_crc};
				default: prdata <= 32'h0000_0000;
			endcase
		end else begin
			pready <= 1'b0;
			pslverr <= 1'b0;
		end
	end

	// ********************************
	// Setup block loader
	// ********************************
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			ld_state <= LD_IDLE;
			blk_idx <= 8'h00;
			crc_acc <= 16'h0000;
			rx_crc_lo <= 8'h00;
			commit <= 1'b0;
			load_ok <= 1'b0;
			load_bad <= 1'b0;
		end else begin
			commit <= 1'b0;
			if (cmd_strobe) begin
				if (pwdata[7:0] == CMD_SETUP) begin
					ld_state <= ld_state == LD_IDLE ? LD_ARM : LD_SETUP;
					blk_idx <= 8'h00;
					crc_acc <= 16'h0000;
					load_ok <= 1'b0;
					load_bad <= 1'b0;
				end else begin
					ld_state <= LD_IDLE;
				end
			end else if (data_strobe && ld_state == LD_SETUP) begin
				blk_idx <= blk_idx + 8'h01;
				if (blk_idx < 8'(DATA_LEN)) begin
					stage[blk_idx] <= pwdata[7:0];
					crc_acc <= crc16_byte(crc_acc, pwdata[7:0]);
				end else if (blk_idx == 8'(OFS_CRC_LO)) begin
					rx_crc_lo <= pwdata[7:0];
				end else begin
					ld_state <= LD_IDLE;
					if ({pwdata[7:0], rx_crc_lo} == crc_acc) begin
						commit <= 1'b1;
						load_ok <= 1'b1;
					end else begin
						load_bad <= 1'b1;
					end
				end
			end
		end
	end

	// Whole block swaps in one cycle so no half-loaded setup is ever used
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			for (int i = 0; i < DATA_LEN; i++) begin
				live[i] <= default_byte(i);
			end
		end else if (commit) begin
			for (int i = 0; i < DATA_LEN; i++) begin
				live[i] <= stage[i];
			end
		end
	end

	// ********************************
	// Commands and responses
	// ********************************
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			last_cmd <= 8'h00;
			comms_err <= 1'b0;
			wd_armed <= 1'b0;
			resp_cnt <= 3'h0;
			resp_rd <= 3'h0;
			resp_crc <= 8'h00;
			for (int i = 0; i < RESP_LEN; i++) begin
				resp_buf[i] <= 8'h00;
			end
		end else if (cmd_strobe) begin
			last_cmd <= pwdata[7:0];
			resp_rd <= 3'h0;
			resp_crc <= 8'h00;
			resp_cnt <= 3'h0;
			if (!known_cmd) begin
				comms_err <= 1'b1;
			end else begin
				wd_armed <= 1'b1;
				if (pwdata[7:0] == CMD_GET_LAST) begin
					comms_err <= 1'b0;
					resp_buf[0] <= last_cmd;
					resp_cnt <= 3'h1;
				end else if (pwdata[7:0] == CMD_ALL_KEYS) begin
					for (int y = 0; y < RESP_LEN; y++) begin
						resp_buf[y] <= key_touch[8*y +: 8];
					end
					resp_cnt <= 3'(RESP_LEN);
				end
			end
		end else if (resp_pop) begin
			resp_rd <= resp_rd + 3'h1;
			resp_crc <= crc8_byte(resp_crc, resp_buf[resp_rd]);
		end
	end

	// ********************************
	// Time base and key errors
	// ********************************
	logic [14:0] div_cnt;
	logic tick;
	always_ff @(posedge sys_clk) begin
		if (reset || div_cnt == 15'(TICK_LEN - 1)) begin
			div_cnt <= 15'h0000;
		end else begin
			div_cnt <= div_cnt + 15'h0001;
		end
	end
	always_ff @(posedge sys_clk) begin
		tick <= !reset && div_cnt == 15'(TICK_LEN - 1);
	end

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			low_vec <= 48'h0000_0000_0000;
			key_error <= 1'b0;
		end else begin
			if (ref_valid && ref_key < 6'(NUM_KEYS)) begin
				low_vec[ref_key] <= ref_level < low_limit;
			end
			key_error <= |low_vec || cal_error;
		end
	end

	// ********************************
	// Host watchdog and alert pin
	// ********************************
	logic [12:0] wd_cnt;
	logic [12:0] hr_cnt;
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			wd_cnt <= 13'h0000;
			hr_cnt <= 13'h0000;
			hreset_active <= 1'b0;
		end else if (hreset_active) begin
			if (tick) begin
				hr_cnt <= hr_cnt + 13'h0001;
				hreset_active <= hr_cnt != HRESET_TICKS - 13'h0001;
			end
		end else if (access || !wd_armed || !alert_cfg[AL_WDOG]) begin
			wd_cnt <= 13'h0000;
		end else if (tick) begin
			if (wd_cnt == 13'(WDOG_LEN - 1)) begin
				wd_cnt <= 13'h0000;
				hr_cnt <= 13'h0000;
				hreset_active <= 1'b1;
			end else begin
				wd_cnt <= wd_cnt + 13'h0001;
			end
		end
	end

	always_comb begin
		alert_cond = (alert_cfg[AL_KEYERR] && key_error) || (alert_cfg[AL_PRESS] && |key_touch)
			|| (alert_cfg[AL_SLEEP] && sleep_active) || (alert_cfg[AL_NVERR] && eeprom_error)
			|| (alert_cfg[AL_SYNCERR] && mains_sync_enable_err) || (alert_cfg[AL_COMMS] && comms_err)
			|| (alert_cfg[AL_WDOG] && hreset_active);
	end

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			alert_pin <= 1'b1;
		end else if (!sleep_active || alert_cfg[AL_SLEEP]) begin
			alert_pin <= alert_cfg[AL_POL] ? alert_cond : !alert_cond;
		end
	end

	// ********************************
	// Burst scheduler
	// ********************************
	logic sync_meta, sync_pin, sync_prev, sync_fall;
	logic [1:0] auto_bl [NUM_KEYS];
	logic auto_taken;
	logic [5:0] scan_key;
	logic [3:0] slot_cnt, slot_len, spacing_idx;
	logic [12:0] wait_cnt;

	always_ff @(posedge sys_clk) begin
		sync_meta <= wake_sync_pin;
		sync_pin <= sync_meta;
		sync_prev <= sync_pin;
	end
	assign sync_fall = sync_prev && !sync_pin;
	assign spacing_idx = live[OFS_SPACE][3:0] > SPACING_MAX_INDEX ? SPACING_MAX_INDEX : live[OFS_SPACE][3:0];
	assign slot_len = spacing_idx == 4'h0 ? AUTO_SLOT_BASE + {2'b00, auto_bl[scan_key]} : spacing_idx + 4'h1;

	// Taken once after reset; later block loads do not move the auto slots
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			auto_taken <= 1'b0;
			// Known slot length in the cycle before capture
			for (int k = 0; k < NUM_KEYS; k++) begin
				auto_bl[k] <= 2'h0;
			end
		end else if (!auto_taken) begin
			auto_taken <= 1'b1;
			for (int k = 0; k < NUM_KEYS; k++) begin
				auto_bl[k] <= live[OFS_OPT + k][5:4];
			end
		end
	end

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			sc_state <= SC_RUN;
			scan_key <= 6'h00;
			slot_cnt <= 4'h0;
			wait_cnt <= 13'h0000;
			mains_sync_enable_err <= 1'b0;
		end else begin
			unique case (sc_state)
				SC_RUN: if (tick && auto_taken) begin
					if (slot_cnt + 4'h1 < slot_len) begin
						slot_cnt <= slot_cnt + 4'h1;
					end else begin
						slot_cnt <= 4'h0;
						scan_key <= scan_key == 6'(NUM_KEYS - 1) ? 6'h00 : scan_key + 6'h01;
						if (scan_key == 6'(NUM_KEYS - 1) && live[OFS_GLOBAL][6]) begin
							sc_state <= SC_WAIT_SYNC;
							wait_cnt <= 13'h0000;
						end
					end
				end
				SC_WAIT_SYNC: if (sync_fall) begin
					sc_state <= SC_RUN;
					mains_sync_enable_err <= 1'b0;
				end else if (tick) begin
					wait_cnt <= wait_cnt + 13'h0001;
					if (wait_cnt == SYNC_WAIT_TICKS - 13'h0001) begin
						sc_state <= SC_RUN;
						mains_sync_enable_err <= 1'b1;
					end
				end
			endcase
		end
	end

	// ********************************
	// Per-key setup presented at each burst
	// ********************************
	logic slot_begin;
	assign slot_begin = auto_taken && sc_state == SC_RUN && tick && slot_cnt == 4'h0;

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			burst_start <= 1'b0;
			burst_key <= 6'h00;
			neg_threshold <= 5'h00;
			pos_threshold <= 5'h00;
			normal_integrator_limit <= 4'h0;
			fast_integrator_limit <= 4'h0;
			negative_recal_delay <= 8'h00;
			positive_recal_delay <= 4'h0;
			burst_length <= 7'h00;
			adjacent_suppress_enable <= 1'b0;
			scope_pulse_enable <= 1'b0;
		end else begin
			burst_start <= slot_begin && live[OFS_INTEG + 32'(scan_key)][3:0] != 4'h0;
			if (slot_begin) begin
				burst_key <= scan_key;
				neg_threshold <= {1'b0, live[OFS_THRESH + 32'(scan_key)][3:0]} + THRESH_OFFSET;
				pos_threshold <= {1'b0, live[OFS_THRESH + 32'(scan_key)][7:4]} + THRESH_OFFSET;
				normal_integrator_limit <= live[OFS_INTEG + 32'(scan_key)][3:0];
				fast_integrator_limit <= live[OFS_INTEG + 32'(scan_key)][7:4];
				negative_recal_delay <= live[OFS_NEG_RECAL + 32'(scan_key)];
				positive_recal_delay <= live[OFS_OPT + 32'(scan_key)][3:0];
				burst_length <= {live[OFS_OPT + 32'(scan_key)][5:4], 4'h0} + 7'h10;
				adjacent_suppress_enable <= live[OFS_OPT + 32'(scan_key)][6];
				scope_pulse_enable <= live[OFS_OPT + 32'(scan_key)][7];
			end
		end
	end

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			drop_out_hysteresis <= 2'h0;
			dwell_select <= 2'h0;
			mains_sync_enable <= 1'b0;
			serial_divisor <= 14'h0000;
		end else begin
			drop_out_hysteresis <= live[OFS_GLOBAL][1:0];
			dwell_select <= live[OFS_GLOBAL][5:4];
			mains_sync_enable <= live[OFS_GLOBAL][6];
			serial_divisor <= baud_div(live[OFS_SPACE][7:4]);
		end
	end

	// ********************************
	// Checks
	// ********************************
	property p_alert_level;
		@(posedge sys_clk) disable iff (reset)
		!$past(sleep_active) && !$past(reset) |-> alert_pin == ($past(alert_cfg[AL_POL]) ~^ $past(alert_cond));
	endproperty
	a_alert_level: assert property (p_alert_level) else $error("alert level wrong");
	property p_sleep_hold;
		@(posedge sys_clk) disable iff (reset)
		sleep_active && !alert_cfg[AL_SLEEP] ##1 !reset |-> $stable(alert_pin);
	endproperty
	a_sleep_hold: assert property (p_sleep_hold) else $error("alert moved in sleep");
	property p_comms_err;
		@(posedge sys_clk) disable iff (reset)
		cmd_strobe && !known_cmd |=> comms_err && alert_cfg[AL_COMMS] |-> ##[1:2] alert_pin == alert_cfg[AL_POL];
	endproperty
	a_comms_err: assert property (p_comms_err) else $error("comms error not shown");
	property p_setup_only;
		@(posedge sys_clk) disable iff (reset)
		data_strobe && ld_state != LD_SETUP |=> $stable(blk_idx) && !commit;
	endproperty
	a_setup_only: assert property (p_setup_only) else $error("block taken outside setup");
	property p_crc_gate;
		@(posedge sys_clk) disable iff (reset)
		commit |-> $past(blk_idx) == 8'(BLOCK_LEN - 1) && $past({pwdata[7:0], rx_crc_lo}) == $past(crc_acc);
	endproperty
	a_crc_gate: assert property (p_crc_gate) else $error("block stored with bad crc");
	property p_all_keys;
		@(posedge sys_clk) disable iff (reset)
		cmd_strobe && pwdata[7:0] == CMD_ALL_KEYS |=> resp_cnt == 3'h6 && resp_buf[5] == $past(key_touch[47:40]);
	endproperty
	a_all_keys: assert property (p_all_keys) else $error("key report wrong");
	property p_burst_enable;
		@(posedge sys_clk) disable iff (reset)
		burst_start |-> normal_integrator_limit != 4'h0;
	endproperty
	a_burst_enable: assert property (p_burst_enable) else $error("burst on disabled key");
	property p_sync_wait;
		@(posedge sys_clk) disable iff (reset)
		sc_state == SC_WAIT_SYNC |-> wait_cnt < SYNC_WAIT_TICKS;
	endproperty
	a_sync_wait: assert property (p_sync_wait) else $error("sync wait too long");
	property p_hreset_len;
		@(posedge sys_clk) disable iff (reset)
		hreset_active |-> hr_cnt < HRESET_TICKS;
	endproperty
	a_hreset_len: assert property (p_hreset_len) else $error("host reset pulse too long");
	property p_low_signal;
		@(posedge sys_clk) disable iff (reset)
		ref_valid && ref_key < 6'(NUM_KEYS) && ref_level < low_limit |-> ##2 key_error;
	endproperty
	a_low_signal: assert property (p_low_signal) else $error("low signal not flagged");
	property p_slot_bound;
		@(posedge sys_clk) disable iff (reset)
		sc_state == SC_RUN |-> slot_cnt < slot_len && slot_len <= SPACING_MAX_INDEX + 4'h1;
	endproperty
	a_slot_bound: assert property (p_slot_bound) else $error("slot length out of range");
endmodule

// ==== touch_setup_pkg.sv ====
package touch_setup_pkg;
	// ********************************
	// Timing
	// ********************************
	localparam int unsigned CLK_HZ = 100_000_000;
	localparam int unsigned TICK_US = 250;
	localparam int unsigned TICK_CYCLES = CLK_HZ / 1_000_000 * TICK_US;
	localparam int unsigned WDOG_MS = 2000;
	localparam int unsigned WDOG_TICKS = WDOG_MS * 1000 / TICK_US;
	localparam int unsigned HRESET_MS = 150;
	localparam logic [12:0] HRESET_TICKS = 13'(HRESET_MS * 1000 / TICK_US);
	localparam int unsigned SYNC_WAIT_MS = 100;
	localparam logic [12:0] SYNC_WAIT_TICKS = 13'(SYNC_WAIT_MS * 1000 / TICK_US);
	localparam logic [3:0] SPACING_MAX_INDEX = 4'hB;
	localparam logic [3:0] AUTO_SLOT_BASE = 4'h2;
	// ********************************
	// Setup block layout
	// ********************************
	localparam int unsigned NUM_KEYS = 48;
	localparam int unsigned BLOCK_LEN = 247;
	localparam int unsigned DATA_LEN = 245;
	localparam int unsigned OFS_THRESH = 0;
	localparam int unsigned OFS_DRIFT = 48;
	localparam int unsigned OFS_INTEG = 96;
	localparam int unsigned OFS_NEG_RECAL = 144;
	localparam int unsigned OFS_OPT = 192;
	localparam int unsigned OFS_GLOBAL = 240;
	localparam int unsigned OFS_SPACE = 241;
	localparam int unsigned OFS_LIMIT_LO = 242;
	localparam int unsigned OFS_LIMIT_HI = 243;
	localparam int unsigned OFS_ALERT = 244;
	localparam int unsigned OFS_CRC_LO = 245;
	localparam logic [7:0] DEF_THRESH = 8'h26;
	localparam logic [7:0] DEF_DRIFT = 8'h4A;
	localparam logic [7:0] DEF_INTEG = 8'h52;
	localparam logic [7:0] DEF_NEG_RECAL = 8'h14;
	localparam logic [7:0] DEF_OPT = 8'h26;
	localparam logic [7:0] DEF_GLOBAL = 8'h11;
	localparam logic [7:0] DEF_SPACE = 8'h00;
	localparam logic [15:0] DEF_LIMIT = 16'h0064;
	localparam logic [7:0] DEF_ALERT = 8'h6C;
	localparam logic [4:0] THRESH_OFFSET = 5'h04;
	localparam int unsigned AL_POL = 7;
	localparam int unsigned AL_KEYERR = 6;
	localparam int unsigned AL_PRESS = 5;
	localparam int unsigned AL_SLEEP = 4;
	localparam int unsigned AL_NVERR = 3;
	localparam int unsigned AL_SYNCERR = 2;
	localparam int unsigned AL_COMMS = 1;
	localparam int unsigned AL_WDOG = 0;
	// ********************************
	// Commands and CRC
	// ********************************
	localparam logic [7:0] CMD_SETUP = 8'h01;
	localparam logic [7:0] CMD_ALL_KEYS = 8'h07;
	localparam logic [7:0] CMD_GET_LAST = 8'h0F;
	localparam logic [15:0] CRC16_POLY = 16'h1021;
	localparam logic [7:0] CRC8_POLY = 8'h8C;
	localparam int unsigned RESP_LEN = 6;
	// ********************************
	// APB map
	// ********************************
	localparam logic [7:0] ADDR_CMD = 8'h00;
	localparam logic [7:0] ADDR_BLOCK = 8'h04;
	localparam logic [7:0] ADDR_STATUS = 8'h08;
	localparam logic [7:0] ADDR_RESP = 8'h0C;
	localparam logic [7:0] ADDR_LAST = 8'h10;
	localparam logic [7:0] ADDR_RESP_CRC = 8'h14;

	function automatic logic [15:0] crc16_byte(input logic [15:0] crc_in, input logic [7:0] data);
		logic [15:0] c;
		c = crc_in ^ {data, 8'h00};
		for (int i = 0; i < 8; i++) begin
			c = c[15] ? ({c[14:0], 1'b0} ^ CRC16_POLY) : {c[14:0], 1'b0};
		end
		return c;
	endfunction

	function automatic logic [7:0] crc8_byte(input logic [7:0] crc_in, input logic [7:0] data);
		logic [7:0] c;
		logic [7:0] d;
		logic fb;
		c = crc_in;
		d = data;
		for (int i = 0; i < 8; i++) begin
			fb = c[0] ^ d[0];
			d = d >> 1;
			c = c >> 1;
			if (fb) begin
				c = c ^ CRC8_POLY;
			end
		end
		return c;
	endfunction
endpackage

// ==== touch_host_model.sv ====
`timescale 1ns/1ns
// ****
// Host APB master
// ****
module touch_host_model
	import touch_setup_pkg::*;
(
	input wire logic sys_clk,
	output logic psel,
	output logic penable,
	output logic pwrite,
	output logic [7:0] paddr,
	output logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr
);
	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
	end
	task xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q, output logic e);
		@(posedge sys_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1'b1;
		do @(posedge sys_clk); while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		// Stale data must not look valid
		pwdata <= ~d;
	endtask
	task cmd(input logic [7:0] c);
		logic [31:0] q;
		logic e;
		xfer(1'b1, ADDR_CMD, {24'h0, c}, q, e);
	endtask
	task load(input logic [7:0] glob, input logic [7:0] alert, input logic [15:0] flip);
		logic [15:0] crc;
		logic [7:0] b;
		logic [31:0] q;
		logic e;
		crc = 16'h0000;
		cmd(CMD_SETUP);
		cmd(CMD_SETUP);
		for (int i = 0; i < 245; i++) begin
			b = i < 48 ? 8'h26 : i < 96 ? 8'h4A : i < 144 ? 8'h52 : i < 192 ? 8'h14 : i < 240 ? 8'h26 :
				i == 240 ? glob : i == 242 ? 8'h64 : i == 244 ? alert : 8'h00;
			xfer(1'b1, ADDR_BLOCK, {24'h0, b}, q, e);
			crc = crc ^ {b, 8'h00};
			for (int k = 0; k < 8; k++) crc = crc[15] ? ({crc[14:0], 1'b0} ^ 16'h1021) : {crc[14:0], 1'b0};
		end
		crc = crc ^ flip;
		xfer(1'b1, ADDR_BLOCK, {24'h0, crc[7:0]}, q, e);
		xfer(1'b1, ADDR_BLOCK, {24'h0, crc[15:8]}, q, e);
	endtask
endmodule

// ==== test_touch_setup_block.sv ====
`timescale 1ns/1ns
module test_touch_setup_block
	import touch_setup_pkg::*;
();
	localparam logic [47:0] KEYS = 48'hA5_00_3C_00_80_01;
	logic sys_clk, reset, psel, penable, pwrite, pready, pslverr, ref_valid, eeprom_error, alert_pin;
	logic burst_start, key_error, mains_sync_enable, cal_error, sleep_active, err;
	logic [7:0] paddr, c8;
	logic [31:0] pwdata, prdata, q;
	logic [47:0] key_touch;
	logic [15:0] ref_level;
	logic [5:0] ref_key;
	logic [4:0] neg_threshold, pos_threshold;
	logic [3:0] normal_integrator_limit, fast_integrator_limit;
	logic [6:0] burst_length;
	logic [1:0] drop_out_hysteresis, dwell_select;
	int fails = 0;
	int n_compared = 0;
	touch_setup_block #(.TICK_LEN(10), .WDOG_LEN(20)) u_dut (.sys_clk(sys_clk), .reset(reset), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .key_touch(key_touch), .ref_level(ref_level), .ref_key(ref_key),
		.ref_valid(ref_valid), .cal_error(cal_error), .sleep_active(sleep_active), .eeprom_error(eeprom_error),
		.wake_sync_pin(1'b1), .alert_pin(alert_pin), .burst_start(burst_start), .burst_key(),
		.neg_threshold(neg_threshold), .pos_threshold(pos_threshold),
		.normal_integrator_limit(normal_integrator_limit), .fast_integrator_limit(fast_integrator_limit),
		.negative_recal_delay(), .positive_recal_delay(), .burst_length(burst_length),
		.adjacent_suppress_enable(), .scope_pulse_enable(), .drop_out_hysteresis(drop_out_hysteresis),
		.dwell_select(dwell_select), .mains_sync_enable(mains_sync_enable), .serial_divisor(),
		.key_error(key_error));
	touch_host_model u_host (.sys_clk(sys_clk), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
	initial begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end
	task check(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			fails++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task rd(input logic [7:0] a);
		u_host.xfer(1'b0, a, 32'h0, q, err);
	endtask
	task wt(input int n);
		repeat (n) @(posedge sys_clk);
	endtask
	task report(input logic [15:0] lvl);
		ref_level <= lvl;
		ref_valid <= 1'b1;
		wt(1);
		ref_valid <= 1'b0;
		wt(3);
	endtask
	task finish_test;
		$display("compared %0d, mismatches %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	initial begin
		// Watchdog sized well above the whole sequence
		wt(40000);
		fails++;
		finish_test();
	end
	initial begin
		reset = 1'b1;
		key_touch = 48'h0;
		ref_level = 16'h0;
		ref_key = 6'h03;
		ref_valid = 1'b0;
		eeprom_error = 1'b0;
		cal_error = 1'b0;
		sleep_active = 1'b0;
		wt(12);
		reset <= 1'b0;
		wt(3);
		check(alert_pin, 1);
		check({drop_out_hysteresis, dwell_select, mains_sync_enable}, 5'b01010);
		@(posedge burst_start);
		wt(1);
		check({neg_threshold, pos_threshold}, {5'h0A, 5'h06});
		check({normal_integrator_limit, fast_integrator_limit}, 8'h25);
		check(burst_length, 7'd48);
		$display("defaults done");
		key_touch <= KEYS;
		wt(3);
		check(alert_pin, 0);
		sleep_active <= 1'b1;
		wt(1);
		key_touch <= 48'h0;
		wt(3);
		check(alert_pin, 0);
		sleep_active <= 1'b0;
		key_touch <= KEYS;
		u_host.cmd(CMD_ALL_KEYS);
		c8 = 8'h00;
		for (int y = 0; y < 6; y++) begin
			rd(ADDR_RESP);
			check(q, {24'h0, KEYS[8*y +: 8]});
			for (int k = 0; k < 8; k++) c8 = (c8[0] ^ KEYS[8*y+k]) ? (c8 >> 1) ^ 8'h8C : c8 >> 1;
		end
		rd(ADDR_RESP_CRC);
		check(q, {24'h0, c8});
		key_touch <= 48'h0;
		report(16'd99);
		check({key_error, alert_pin}, 2'b10);
		report(16'd100);
		check({key_error, alert_pin}, 2'b01);
		cal_error <= 1'b1;
		wt(3);
		check({key_error, alert_pin}, 2'b10);
		cal_error <= 1'b0;
		eeprom_error <= 1'b1;
		wt(3);
		check(alert_pin, 0);
		eeprom_error <= 1'b0;
		wt(3);
		check(alert_pin, 1);
		rd(8'h40);
		check(q, 0);
		check(err, 1);
		$display("alerts and keys done");
		u_host.cmd(CMD_SETUP);
		rd(ADDR_STATUS);
		check(q[0], 0);
		u_host.xfer(1'b1, ADDR_BLOCK, 32'h0000_00AA, q, err);
		check(err, 0);
		u_host.cmd(CMD_SETUP);
		rd(ADDR_STATUS);
		check(q[0], 1);
		u_host.load(8'h23, 8'h82, 16'h0001);
		rd(ADDR_STATUS);
		check(q[2:0], 3'b100);
		check(dwell_select, 2'h1);
		u_host.load(8'h23, 8'h82, 16'h0000);
		rd(ADDR_STATUS);
		check(q[2:0], 3'b010);
		check({drop_out_hysteresis, dwell_select}, 4'hE);
		check(alert_pin, 0);
		$display("block load done");
		u_host.cmd(8'h55);
		wt(3);
		check(alert_pin, 1);
		u_host.cmd(CMD_GET_LAST);
		rd(ADDR_RESP);
		check(q, 32'h55);
		check(alert_pin, 0);
		u_host.load(8'h63, 8'h81, 16'h0000);
		u_host.cmd(CMD_ALL_KEYS);
		wt(150);
		check(alert_pin, 0);
		wt(250);
		check(alert_pin, 1);
		wt(5900);
		check(alert_pin, 0);
		rd(ADDR_STATUS);
		check({q[5], mains_sync_enable}, 2'b11);
		$display("commands done");
		finish_test();
	end
endmodule
